/* File: rtl/pp_entry_detect.sv */
//------------------------------------------------------------
// Purpose: Decide programming-mode entry from pin pattern and high voltage
// Assumes: hv_reset_in is a level telling that reset sits at programming voltage
// Notes: Entry fails if the pattern moves inside the stable window
//------------------------------------------------------------
module pp_entry_detect
	import pp_port_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic hv_reset_in,
	input wire logic [3:0] prog_enable_in,
	output logic prog_mode_out
);
	logic [7:0] cnt_r, cnt_nxt;
	logic mode_r, mode_nxt;
	logic failed_r, failed_nxt;

	// Count stable cycles after high voltage arrives
	always_comb begin
		cnt_nxt = cnt_r;
		mode_nxt = mode_r;
		failed_nxt = failed_r;
		if (!hv_reset_in) begin
			cnt_nxt = '0;
			mode_nxt = 1'b0;
			failed_nxt = 1'b0;
		end else if (!mode_r && !failed_r) begin
			if (prog_enable_in != ENTRY_PATTERN) begin
				failed_nxt = 1'b1;
			end else if (cnt_r >= 8'(ENTRY_STABLE_CYC)) begin
				mode_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end
	end

	// Register entry state
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= 8'h00;
			mode_r <= 1'b0;
			failed_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			mode_r <= mode_nxt;
			failed_r <= failed_nxt;
		end
	end

	assign prog_mode_out = mode_r;
endmodule : pp_entry_detect

/* File: rtl/pp_mem_if.sv */
//------------------------------------------------------------
// Purpose: Carrier between the port control and its storage
// Assumes: One clock domain
// Notes: Write strobes are one-cycle pulses
//------------------------------------------------------------
interface pp_mem_if;
	logic [11:0] addr;
	logic [15:0] wdata;
	logic latch_pulse;
	logic flash_commit;
	logic ee_commit;
	logic erase_pulse;
	logic fuse_lo_we;
	logic fuse_hi_we;
	logic lock_we;
	logic [15:0] flash_rdata;
	logic [7:0] ee_rdata;
	logic [7:0] fuse_lo;
	logic [7:0] fuse_hi;
	logic [7:0] lock_bits;
	modport ctrl (output addr, wdata, latch_pulse, flash_commit, ee_commit, erase_pulse,
		fuse_lo_we, fuse_hi_we, lock_we, input flash_rdata, ee_rdata, fuse_lo, fuse_hi, lock_bits);
	modport mem (input addr, wdata, latch_pulse, flash_commit, ee_commit, erase_pulse,
		fuse_lo_we, fuse_hi_we, lock_we, output flash_rdata, ee_rdata, fuse_lo, fuse_hi, lock_bits);
endinterface : pp_mem_if

/* File: rtl/pp_port.sv */
//------------------------------------------------------------
// Purpose: Parallel programming port of a small microcontroller
// Assumes: All pins synchronous to mclk_in; high voltage reported as a level
// Notes: Edges of the load, page latch and write strobes are found by sampling
//------------------------------------------------------------
module pp_port
	import pp_port_pkg::*;
#(
	parameter int PROG_CYCLES = 100,
	parameter int ERASE_CYCLES = 200,
	parameter int FLASH_WORDS = 64,
	parameter int EE_BYTES = 16
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic hv_reset_in,
	input wire logic load_strobe_clock_in,
	input wire logic action_code_bit0_in,
	input wire logic action_code_bit1_in,
	input wire logic byte_sel_low_high_in,
	input wire logic byte_sel_extra_in,
	input wire logic page_latch_strobe_in,
	input wire logic write_n_in,
	input wire logic output_enable_n_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	output logic ready_busy_out,
	output logic prog_mode_out
);
	typedef enum logic [1:0] {ST_READY, ST_BUSY} pstate_t;

	pp_mem_if mif ();
	logic prog_mode;
	logic xt_d_r, pl_d_r, wr_d_r;
	logic [7:0] cmd_r, cmd_nxt;
	logic [11:0] addr_r, addr_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic armed_r, armed_nxt;
	pstate_t st_r, st_nxt;
	op_t pend_r, pend_nxt;
	logic [15:0] busy_cnt_r, busy_cnt_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic xt_rise, pl_rise, wr_fall;
	op_t op;
	logic [1:0] action;

	//------------------------------------------------------------
	// Entry detection and storage
	//------------------------------------------------------------
	pp_entry_detect u_entry (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.hv_reset_in(hv_reset_in),
		.prog_enable_in({page_latch_strobe_in, action_code_bit1_in, action_code_bit0_in, byte_sel_low_high_in}),
		.prog_mode_out(prog_mode)
	);

	pp_store #(.FLASH_WORDS(FLASH_WORDS), .EE_BYTES(EE_BYTES)) u_store (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.mem(mif.mem)
	);

	//------------------------------------------------------------
	// Strobe edge detection
	//------------------------------------------------------------
	// Previous strobe levels
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			xt_d_r <= 1'b0;
			pl_d_r <= 1'b0;
			wr_d_r <= 1'b1;
		end else begin
			xt_d_r <= load_strobe_clock_in;
			pl_d_r <= page_latch_strobe_in;
			wr_d_r <= write_n_in;
		end
	end

	assign wr_fall = prog_mode && wr_d_r && !write_n_in;
	assign xt_rise = prog_mode && !xt_d_r && load_strobe_clock_in;
	assign pl_rise = prog_mode && !pl_d_r && page_latch_strobe_in;
	assign action = {action_code_bit1_in, action_code_bit0_in};

	// Command decode
	always_comb begin
		unique case (cmd_r)
			CMD_CHIP_ERASE: op = OP_ERASE;
			CMD_WR_FLASH: op = OP_WFLASH;
			CMD_WR_EEPROM: op = OP_WEE;
			CMD_WR_FUSE: op = OP_WFUSE;
			CMD_WR_LOCK: op = OP_WLOCK;
			CMD_RD_FUSE_LOCK: op = OP_RFUSE;
			CMD_RD_SIG: op = OP_RSIG;
			CMD_RD_FLASH: op = OP_RFLASH;
			CMD_RD_EEPROM: op = OP_REE;
			default: op = OP_NONE;
		endcase
	end

	//------------------------------------------------------------
	// Load latches
	//------------------------------------------------------------
	// Command, address and data latches plus write arming
	always_comb begin
		cmd_nxt = cmd_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		armed_nxt = armed_r;
		if (xt_rise) begin
			unique case (action)
				ACT_ADDR: begin
					if (byte_sel_low_high_in) addr_nxt[11:8] = data_in[3:0];
					else addr_nxt[7:0] = data_in;
				end
				ACT_DATA: begin
					if (byte_sel_low_high_in) wdata_nxt[15:8] = data_in;
					else wdata_nxt[7:0] = data_in;
				end
				ACT_CMD: begin
					cmd_nxt = data_in;
					armed_nxt = (data_in != CMD_NOP);
				end
				ACT_IDLE: ;
			endcase
		end
		if (!prog_mode) armed_nxt = 1'b0;
	end

	// Register latches
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_r <= CMD_NOP;
			addr_r <= 12'h000;
			wdata_r <= ERASED_WORD;
			armed_r <= 1'b0;
		end else begin
			cmd_r <= cmd_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			armed_r <= armed_nxt;
		end
	end

	//------------------------------------------------------------
	// Operation sequencer
	//------------------------------------------------------------
	// Busy timing of erase and program operations
	always_comb begin
		st_nxt = st_r;
		pend_nxt = pend_r;
		busy_cnt_nxt = busy_cnt_r;
		unique case (st_r)
			ST_READY: begin
				if (wr_fall && armed_r && (op == OP_ERASE || op == OP_WFLASH || op == OP_WEE ||
						op == OP_WFUSE || op == OP_WLOCK)) begin
					st_nxt = ST_BUSY;
					pend_nxt = op;
					busy_cnt_nxt = (op == OP_ERASE) ? 16'(ERASE_CYCLES) : 16'(PROG_CYCLES);
				end
			end
			ST_BUSY: begin
				if (busy_cnt_r <= 16'h0001) begin
					st_nxt = ST_READY;
					pend_nxt = OP_NONE;
					busy_cnt_nxt = 16'h0000;
				end else begin
					busy_cnt_nxt = busy_cnt_r - 16'h0001;
				end
			end
			default: st_nxt = ST_READY;
		endcase
		if (!prog_mode) begin
			st_nxt = ST_READY;
			pend_nxt = OP_NONE;
			busy_cnt_nxt = 16'h0000;
		end
	end

	// Register sequencer
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= ST_READY;
			pend_r <= OP_NONE;
			busy_cnt_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			pend_r <= pend_nxt;
			busy_cnt_r <= busy_cnt_nxt;
		end
	end

	// Erase, commit and write enables fire as the write strobe starts an operation; latch_pulse fires on the page latch rise
	assign mif.addr = addr_r;
	assign mif.wdata = wdata_r;
	assign mif.latch_pulse = pl_rise && armed_r && (op == OP_WFLASH || op == OP_WEE);
	assign mif.erase_pulse = (st_r == ST_READY) && (st_nxt == ST_BUSY) && op == OP_ERASE;
	assign mif.flash_commit = (st_r == ST_READY) && (st_nxt == ST_BUSY) && op == OP_WFLASH;
	assign mif.ee_commit = (st_r == ST_READY) && (st_nxt == ST_BUSY) && op == OP_WEE;
	assign mif.fuse_lo_we = (st_r == ST_READY) && (st_nxt == ST_BUSY) && op == OP_WFUSE &&
		!byte_sel_low_high_in && !byte_sel_extra_in;
	assign mif.fuse_hi_we = (st_r == ST_READY) && (st_nxt == ST_BUSY) && op == OP_WFUSE &&
		byte_sel_low_high_in && !byte_sel_extra_in;
	assign mif.lock_we = (st_r == ST_READY) && (st_nxt == ST_BUSY) && op == OP_WLOCK;

	//------------------------------------------------------------
	// Read path
	//------------------------------------------------------------
	// Select read byte from the loaded command and byte selects
	always_comb begin
		dout_nxt = dout_r;
		if (!output_enable_n_in) begin
			unique case (op)
				OP_RFLASH: dout_nxt = byte_sel_low_high_in ? mif.flash_rdata[15:8] : mif.flash_rdata[7:0];
				OP_REE: dout_nxt = mif.ee_rdata;
				OP_RFUSE: begin
					if (byte_sel_extra_in) dout_nxt = mif.lock_bits;
					else if (byte_sel_low_high_in) dout_nxt = mif.fuse_hi;
					else dout_nxt = mif.fuse_lo;
				end
				OP_RSIG: dout_nxt = SIG_DEFAULT;
				default: dout_nxt = ERASED_BYTE;
			endcase
		end
	end

	// Register read data
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) dout_r <= 8'h00;
		else dout_r <= dout_nxt;
	end

	assign data_out = dout_r;
	assign data_oe_out = prog_mode && !output_enable_n_in;
	assign ready_busy_out = (st_r == ST_READY);
	assign prog_mode_out = prog_mode;
endmodule : pp_port

/* File: rtl/pp_port_pkg.sv */
//------------------------------------------------------------
// Purpose: Shared constants and types for the parallel programming port
// Assumes: Single 25 MHz clock, all pins synchronous to it
// Notes: Command codes, action codes, page geometry, timing
//------------------------------------------------------------
package pp_port_pkg;
	// Clock period and pin timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int ENTRY_STABLE_NS = 100;
	localparam int ENTRY_STABLE_CYC = (ENTRY_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ENTRY_TOGGLES = 6;
	// Action codes on the two action-select bits
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// Command bytes
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE_LOCK = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
	// Page geometry
	localparam int FLASH_WORD_BITS = 5;
	localparam int FLASH_PAGE_BITS = 7;
	localparam int EE_BYTE_BITS = 2;
	localparam int EE_PAGE_BITS = 7;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] SIG_DEFAULT = 8'h5A; // Arbitrary identity value
	localparam logic [3:0] ENTRY_PATTERN = 4'h0;
	// Decoded operations
	typedef enum logic [3:0] {
		OP_NONE, OP_ERASE, OP_WFUSE, OP_WLOCK, OP_WFLASH, OP_WEE,
		OP_RSIG, OP_RFUSE, OP_RFLASH, OP_REE
	} op_t;
endpackage : pp_port_pkg

/* File: rtl/pp_store.sv */
//------------------------------------------------------------
// Purpose: Page buffers, memory arrays and fuse/lock storage
// Assumes: Small flip-flop arrays stand in for the nonvolatile cells
// Notes: Erase sets memories and lock bits to the erased value
//------------------------------------------------------------
module pp_store
	import pp_port_pkg::*;
#(
	parameter int FLASH_WORDS = 64,
	parameter int EE_BYTES = 16
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	pp_mem_if.mem mem
);
	localparam int FPG = 1 << FLASH_WORD_BITS;
	localparam int EPG = 1 << EE_BYTE_BITS;
	logic [15:0] fbuf_r [FPG];
	logic [7:0] ebuf_r [EPG];
	logic [15:0] flash_r [FLASH_WORDS];
	logic [7:0] ee_r [EE_BYTES];
	logic [7:0] fuse_lo_r, fuse_hi_r, lock_r;
	logic [FLASH_WORD_BITS-1:0] widx;
	logic [EE_BYTE_BITS-1:0] bidx;
	logic [11:0] fpage_base, epage_base;

	assign widx = mem.addr[FLASH_WORD_BITS-1:0];
	assign bidx = mem.addr[EE_BYTE_BITS-1:0];
	assign fpage_base = {mem.addr[11:FLASH_WORD_BITS], {FLASH_WORD_BITS{1'b0}}};
	assign epage_base = {mem.addr[11:EE_BYTE_BITS], {EE_BYTE_BITS{1'b0}}};

	// Per-entry storage, page buffers and commits
	genvar i;
	generate
		for (i = 0; i < FPG; i++) begin : g_fbuf
			always_ff @(posedge mclk_in or negedge resetn_in) begin
				if (!resetn_in) fbuf_r[i] <= ERASED_WORD;
				else if (mem.latch_pulse && widx == i) fbuf_r[i] <= mem.wdata;
			end
		end
		for (i = 0; i < EPG; i++) begin : g_ebuf
			always_ff @(posedge mclk_in or negedge resetn_in) begin
				if (!resetn_in) ebuf_r[i] <= ERASED_BYTE;
				else if (mem.latch_pulse && bidx == i) ebuf_r[i] <= mem.wdata[7:0];
			end
		end
		for (i = 0; i < FLASH_WORDS; i++) begin : g_flash
			always_ff @(posedge mclk_in or negedge resetn_in) begin
				if (!resetn_in) flash_r[i] <= ERASED_WORD;
				else if (mem.erase_pulse) flash_r[i] <= ERASED_WORD;
				else if (mem.flash_commit && (fpage_base >> FLASH_WORD_BITS) == (12'(i) >> FLASH_WORD_BITS))
					flash_r[i] <= fbuf_r[i % FPG];
			end
		end
		for (i = 0; i < EE_BYTES; i++) begin : g_ee
			always_ff @(posedge mclk_in or negedge resetn_in) begin
				if (!resetn_in) ee_r[i] <= ERASED_BYTE;
				else if (mem.erase_pulse) ee_r[i] <= ERASED_BYTE;
				else if (mem.ee_commit && (epage_base >> EE_BYTE_BITS) == (12'(i) >> EE_BYTE_BITS))
					ee_r[i] <= ebuf_r[i % EPG];
			end
		end
	endgenerate

	// Fuse and lock storage; lock writes can only clear bits, erase sets lock bits back
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fuse_lo_r <= ERASED_BYTE;
			fuse_hi_r <= ERASED_BYTE;
			lock_r <= ERASED_BYTE;
		end else begin
			if (mem.fuse_lo_we) fuse_lo_r <= mem.wdata[7:0];
			if (mem.fuse_hi_we) fuse_hi_r <= mem.wdata[7:0];
			if (mem.erase_pulse) lock_r <= ERASED_BYTE;
			else if (mem.lock_we) lock_r <= lock_r & mem.wdata[7:0];
		end
	end

	assign mem.flash_rdata = flash_r[mem.addr % FLASH_WORDS];
	assign mem.ee_rdata = ee_r[mem.addr % EE_BYTES];
	assign mem.fuse_lo = fuse_lo_r;
	assign mem.fuse_hi = fuse_hi_r;
	assign mem.lock_bits = lock_r;
endmodule : pp_store

/* File: test/pp_port_checker.sv */
//------------------------------------------------------------
// Purpose: Pin-level checks on the programming port
// Assumes: Busy counts match the parameters given to the design
// Notes: Busy span checked within one cycle of the set count
//------------------------------------------------------------
module pp_port_checker #(
	parameter int PROG_CYCLES = 100,
	parameter int ERASE_CYCLES = 200
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic hv_reset_in,
	input wire logic load_strobe_clock_in,
	input wire logic action_code_bit0_in,
	input wire logic action_code_bit1_in,
	input wire logic byte_sel_low_high_in,
	input wire logic byte_sel_extra_in,
	input wire logic page_latch_strobe_in,
	input wire logic write_n_in,
	input wire logic output_enable_n_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_out,
	input wire logic ready_busy_out,
	input wire logic prog_mode_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);
	logic [15:0] low_cnt_r;
	logic [15:0] low_cnt_nxt;
	logic [3:0] pins;
	// Counts cycles with ready low
	always_comb begin
		low_cnt_nxt = ready_busy_out ? 16'h0000 : low_cnt_r + 16'h0001;
		pins = {page_latch_strobe_in, action_code_bit1_in, action_code_bit0_in, byte_sel_low_high_in};
	end
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			low_cnt_r <= 16'h0000;
		end else begin
			low_cnt_r <= low_cnt_nxt;
		end
	end
	property p_oe_follows;
		data_oe_out == (prog_mode_out && !output_enable_n_in);
	endproperty
	a_oe_follows: assert property (p_oe_follows) else $error("bus enable wrong");
	property p_busy_cause;
		$fell(ready_busy_out) |-> !$past(write_n_in) && $past(write_n_in, 2);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write edge");
	property p_busy_mode;
		$fell(ready_busy_out) |-> $past(prog_mode_out);
	endproperty
	a_busy_mode: assert property (p_busy_mode) else $error("busy outside mode");
	property p_busy_span;
		$rose(ready_busy_out) |-> low_cnt_r inside {[PROG_CYCLES - 1:PROG_CYCLES + 1],
			[ERASE_CYCLES - 1:ERASE_CYCLES + 1]};
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy length wrong");
	property p_busy_bound;
		!ready_busy_out |-> low_cnt_r <= ERASE_CYCLES + 1;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
	property p_entry_hv;
		$rose(prog_mode_out) |-> hv_reset_in && $past(hv_reset_in, 3);
	endproperty
	a_entry_hv: assert property (p_entry_hv) else $error("entry without voltage");
	property p_entry_pins;
		$rose(prog_mode_out) |-> pins == 4'h0 && $past(pins, 3) == 4'h0;
	endproperty
	a_entry_pins: assert property (p_entry_pins) else $error("entry pattern wrong");
	sequence s_quiet_read;
		(prog_mode_out && ready_busy_out && !output_enable_n_in && !load_strobe_clock_in
			&& $stable({byte_sel_low_high_in, byte_sel_extra_in}))[*3];
	endsequence
	property p_read_holds;
		s_quiet_read |-> $stable(data_out);
	endproperty
	a_read_holds: assert property (p_read_holds) else $error("read byte moved");
	c_entry: cover property ($rose(prog_mode_out));
	c_erase: cover property ($rose(ready_busy_out) && low_cnt_r > PROG_CYCLES + 1);
	c_read: cover property (data_oe_out);
endmodule : pp_port_checker

bind pp_port pp_port_checker #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_pp_port_checker (
	.mclk_in(mclk_in), .resetn_in(resetn_in), .hv_reset_in(hv_reset_in),
	.load_strobe_clock_in(load_strobe_clock_in), .action_code_bit0_in(action_code_bit0_in),
	.action_code_bit1_in(action_code_bit1_in), .byte_sel_low_high_in(byte_sel_low_high_in),
	.byte_sel_extra_in(byte_sel_extra_in), .page_latch_strobe_in(page_latch_strobe_in),
	.write_n_in(write_n_in), .output_enable_n_in(output_enable_n_in), .data_out(data_out),
	.data_oe_out(data_oe_out), .ready_busy_out(ready_busy_out), .prog_mode_out(prog_mode_out));

/* File: test/pp_prog_model.sv */
//------------------------------------------------------------
// Purpose: Programmer driving the port pins
// Assumes: Pins change on falling clock edges only
// Notes: Released bus shows the inverse of the last driven byte
//------------------------------------------------------------
module pp_prog_model
	import pp_port_pkg::*;
(
	input wire logic mclk_in,
	input wire logic ready_busy_in,
	input wire logic [7:0] data_bus_in,
	output logic hv_out,
	output logic load_out,
	output logic act0_out,
	output logic act1_out,
	output logic sel_hl_out,
	output logic sel_extra_out,
	output logic page_latch_out,
	output logic write_n_out,
	output logic oe_n_out,
	output logic bus_en_out,
	output logic [7:0] bus_drv_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PULSE_CYC = 7;
	// Idle pin levels
	initial begin
		{hv_out, load_out, act0_out, act1_out, sel_hl_out, sel_extra_out, page_latch_out} = 7'h00;
		{write_n_out, oe_n_out, bus_en_out} = 3'h7;
		bus_drv_out = 8'h00;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : gap
	task automatic leave;
		hv_out = 1'b0;
		gap(2);
	endtask : leave
	task automatic enter(input logic glitch);
		hv_out = 1'b0;
		{page_latch_out, act1_out, act0_out, sel_hl_out} = ENTRY_PATTERN;
		repeat (ENTRY_TOGGLES) begin
			load_out = 1'b1;
			gap(PULSE_CYC);
			load_out = 1'b0;
			gap(PULSE_CYC);
		end
		gap(ENTRY_STABLE_CYC);
		hv_out = 1'b1;
		if (glitch) begin
			gap(1);
			sel_hl_out = 1'b1;
			gap(1);
			sel_hl_out = 1'b0;
		end
		gap(12);
	endtask : enter
	task automatic pulse_load(input logic [1:0] act, input logic bs, input logic [7:0] val);
		{act1_out, act0_out} = act;
		sel_hl_out = bs;
		bus_drv_out = val;
		gap(2);
		load_out = 1'b1;
		gap(PULSE_CYC);
		load_out = 1'b0;
		gap(2);
	endtask : pulse_load
	task automatic latch;
		page_latch_out = 1'b1;
		gap(PULSE_CYC);
		page_latch_out = 1'b0;
		gap(2);
	endtask : latch
	task automatic write(input logic wait_done, input logic b1, output logic busy);
		sel_hl_out = b1;
		write_n_out = 1'b0;
		gap(3);
		busy = ~ready_busy_in;
		gap(PULSE_CYC - 3);
		write_n_out = 1'b1;
		gap(2);
		sel_hl_out = 1'b0;
		for (int i = 0; i < 400 && wait_done && !ready_busy_in; i++) gap(1);
	endtask : write
	task automatic read(input logic b1, input logic b2, output logic [7:0] val);
		{sel_hl_out, sel_extra_out} = {b1, b2};
		bus_en_out = 1'b0;
		oe_n_out = 1'b0;
		gap(3);
		val = data_bus_in;
		gap(PULSE_CYC - 3);
		oe_n_out = 1'b1;
		gap(1);
		{bus_en_out, sel_extra_out} = 2'h2;
		gap(1);
	endtask : read
endmodule : pp_prog_model

/* File: test/test_pp_port.sv */
//------------------------------------------------------------
// Purpose: Self-checking bench for the programming port
// Assumes: Short busy counts so the run stays brief
// Notes: Bus level resolved from both drivers' enables
//------------------------------------------------------------
module test_pp_port;
	timeunit 1ns;
	timeprecision 1ps;
	import pp_port_pkg::*;
	localparam int PROG_N = 8;
	localparam int ERASE_N = 20;
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic hv, ls, a0, a1, sel_hl, sel_x, pl, wr_n, oe_n, bus_en, oe, rdy, pm, b;
	logic [7:0] bus_drv, dout;
	int miscompares = 0;
	int n_tests = 0;
	wire logic [7:0] data_bus = oe ? dout : (bus_en ? bus_drv : ~bus_drv);
	// 25 MHz clock
	always #20 mclk_in = ~mclk_in;
	pp_port #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) u_pp_port (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .hv_reset_in(hv), .load_strobe_clock_in(ls), .action_code_bit0_in(a0),
		.action_code_bit1_in(a1), .byte_sel_low_high_in(sel_hl), .byte_sel_extra_in(sel_x),
		.page_latch_strobe_in(pl), .write_n_in(wr_n), .output_enable_n_in(oe_n), .data_in(data_bus),
		.data_out(dout), .data_oe_out(oe), .ready_busy_out(rdy), .prog_mode_out(pm));
	pp_prog_model u_pp_prog_model (.mclk_in(mclk_in), .ready_busy_in(rdy), .data_bus_in(data_bus),
		.hv_out(hv), .load_out(ls), .act0_out(a0), .act1_out(a1), .sel_hl_out(sel_hl), .sel_extra_out(sel_x),
		.page_latch_out(pl), .write_n_out(wr_n), .oe_n_out(oe_n), .bus_en_out(bus_en), .bus_drv_out(bus_drv));
	//------------------------------------------------------------
	// Access and compare tasks
	//------------------------------------------------------------
	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask : chk1
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: byte %h, want %h", $time, got, exp);
		end
	endtask : chk8
	task automatic cmd(input logic [7:0] v);
		u_pp_prog_model.pulse_load(ACT_CMD, 1'b0, v);
	endtask : cmd
	task automatic adr(input logic h, input logic [7:0] v);
		u_pp_prog_model.pulse_load(ACT_ADDR, h, v);
	endtask : adr
	task automatic dat(input logic h, input logic [7:0] v);
		u_pp_prog_model.pulse_load(ACT_DATA, h, v);
	endtask : dat
	task automatic rdchk(input logic h, input logic x, input logic [7:0] exp);
		logic [7:0] got;
		u_pp_prog_model.read(h, x, got);
		chk8(got, exp);
	endtask : rdchk
	task automatic wrchk(input logic h, input logic exp);
		logic busy;
		u_pp_prog_model.write(1'b1, h, busy);
		chk1(busy, exp);
	endtask : wrchk
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		repeat (5) @(negedge mclk_in);
		resetn_in = 1'b1;
		chk1(rdy, 1'b1);
		u_pp_prog_model.enter(1'b1);
		chk1(pm, 1'b0);
		u_pp_prog_model.enter(1'b0);
		chk1(pm, 1'b1);
		cmd(CMD_CHIP_ERASE);
		u_pp_prog_model.write(1'b0, 1'b0, b);
		chk1(b, 1'b1);
		u_pp_prog_model.write(1'b1, 1'b0, b);
		repeat (12) begin
			@(negedge mclk_in);
			chk1(rdy, 1'b1);
		end
		cmd(CMD_WR_FUSE);
		dat(1'b0, 8'hA5);
		wrchk(1'b0, 1'b1);
		dat(1'b0, 8'h3C);
		wrchk(1'b1, 1'b1);
		cmd(CMD_WR_LOCK);
		dat(1'b0, 8'hFC);
		wrchk(1'b0, 1'b1);
		cmd(CMD_RD_FUSE_LOCK);
		rdchk(1'b0, 1'b0, 8'hA5);
		rdchk(1'b1, 1'b0, 8'h3C);
		rdchk(1'b0, 1'b1, 8'hFC);
		cmd(CMD_WR_FLASH);
		adr(1'b1, 8'h00);
		adr(1'b0, 8'h21);
		dat(1'b0, 8'h34);
		dat(1'b1, 8'h12);
		u_pp_prog_model.latch();
		adr(1'b0, 8'h22);
		dat(1'b0, 8'h78);
		dat(1'b1, 8'h56);
		u_pp_prog_model.latch();
		wrchk(1'b0, 1'b1);
		cmd(CMD_RD_FLASH);
		u_pp_prog_model.pulse_load(ACT_IDLE, 1'b0, CMD_CHIP_ERASE);
		wrchk(1'b0, 1'b0);
		adr(1'b0, 8'h21);
		rdchk(1'b0, 1'b0, 8'h34);
		rdchk(1'b1, 1'b0, 8'h12);
		adr(1'b0, 8'h22);
		rdchk(1'b0, 1'b0, 8'h78);
		rdchk(1'b1, 1'b0, 8'h56);
		adr(1'b0, 8'h01);
		rdchk(1'b0, 1'b0, ERASED_BYTE);
		cmd(CMD_WR_EEPROM);
		adr(1'b0, 8'h05);
		dat(1'b0, 8'h9C);
		u_pp_prog_model.latch();
		wrchk(1'b0, 1'b1);
		cmd(CMD_RD_EEPROM);
		rdchk(1'b0, 1'b0, 8'h9C);
		adr(1'b0, 8'h01);
		rdchk(1'b0, 1'b0, ERASED_BYTE);
		wrchk(1'b0, 1'b0);
		cmd(CMD_RD_SIG);
		adr(1'b0, 8'h00);
		rdchk(1'b0, 1'b0, SIG_DEFAULT);
		cmd(CMD_NOP);
		wrchk(1'b0, 1'b0);
		// locked part erased before fuse rewrite
		cmd(CMD_CHIP_ERASE);
		u_pp_prog_model.write(1'b1, 1'b0, b);
		chk1(b, 1'b1);
		cmd(CMD_WR_FUSE);
		dat(1'b0, 8'hE0);
		wrchk(1'b0, 1'b1);
		dat(1'b0, 8'h80);
		wrchk(1'b1, 1'b1);
		cmd(CMD_RD_FUSE_LOCK);
		rdchk(1'b0, 1'b1, ERASED_BYTE);
		rdchk(1'b0, 1'b0, 8'hE0);
		rdchk(1'b1, 1'b0, 8'h80);
		u_pp_prog_model.leave();
		chk1(pm, 1'b0);
		chk1(rdy, 1'b1);
		end_of_test();
	end
	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge mclk_in);
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule : test_pp_port
